// ### hdl/srf_spi_regs.sv
// Summary of operation
// - Any latched fault drives the partial shutdown output until cleared.
// - Faults clear by fault clear bit write or enable reset pulse.
// - Enable low longer than the pulse window starts full shutdown.
// - Enable reset pulse clears only fault latches, never control settings.
// - Slave port; each frame is an 8-bit command plus 8 data bits.
// - With select_n high, clock and data ignored and serial_out released.
// - Sample on falling serial clock edge, change output on rising edge.
// - Frames travel most significant bit first in both directions.
// - Only exactly sixteen clocks make a valid frame; others are discarded.
// - Bit 15 selects read, bits 12..8 address, bits 7..0 data.
// - Write frames return the register value held before the write.
// - Read frames return the addressed register in the low byte.
// - Reserved bits reset to zero and stay zero.
// - Lock field in 0x0d blocks writes to other control registers.
// - Fault status bit 7 reads the OR of all latched faults.
// - Fault status bits 6..0 hold the seven summary fault flags.
// - Each phase diagnostic register holds its eight phase flags.
// - The four status registers are read-only and reset to zero.
// - Writing one to fault clear bit clears latches and self-clears.
// - Enable low past the pulse window means sleep with the serial bus disabled.
`timescale 1ns/10ps
`default_nettype none
module srf_spi_regs #(
  parameter int RST_WINDOW_CYC = srf_pkg::RST_WINDOW_NS / srf_pkg::CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic spiClk,
  input wire logic selectN,
  input wire logic serialIn,
  input wire logic enablePin,
  input wire logic [6:0] faultEvt,
  input wire logic [srf_pkg::DATA_W-1:0] diagEvtA,
  input wire logic [srf_pkg::DATA_W-1:0] diagEvtB,
  input wire logic [srf_pkg::DATA_W-1:0] diagEvtC,
  output logic serialOut,
  output logic serialOutOe,
  output logic partialShutdown,
  output logic sleepMode,
  output logic lockActive,
  output logic [srf_pkg::CTRL_COUNT*srf_pkg::DATA_W-1:0] ctrlFlat
);
  import srf_pkg::*;

  localparam int LOW_W = $clog2(RST_WINDOW_CYC + 2);
  localparam logic [LOW_W-1:0] LOW_WIN = LOW_W'(RST_WINDOW_CYC);
  localparam logic [LOW_W-1:0] LOW_TOP = LOW_W'(RST_WINDOW_CYC + 1);

  logic [FRAME_BITS-1:0] shift_reg;
  logic [CNT_W-1:0] bitCnt_reg;
  logic rdReq_reg;
  logic outBit_reg;
  logic frameClr_reg;
  logic sleep_reg;
  logic [DATA_W-1:0] readData_reg;
  logic [2:0] syn1_reg, syn2_reg, syn3_reg, synF_reg, prevF_reg;
  logic [LOW_W-1:0] lowCnt_reg;
  logic [6:0] faultLat_reg;
  logic [2:0][DATA_W-1:0] diagLat_reg;
  logic [DATA_W-1:0] ctrl_reg [CTRL_COUNT];
  logic spiRstN, selRise, rdRise, enRise, busOn, faultAny;
  logic [4:0] addr, rdAddr;
  logic addrHiZero, rdHiZero, frameOk, wrValid, wrAllowed, clrFlt, enPulse, clrAll;
  logic [CTRL_IDX_W-1:0] wrIdx, rdIdx;
  logic [DATA_W-1:0] wrData, readMux;
  logic [2:0] lockFieldIn;

  // =========================================================
  // Link side, on the master's clock
  // The core clears the frame state only after it has taken the word,
  // while the master's clock is parked low between frames.
  assign spiRstN = resetn & ~frameClr_reg;

  always_ff @(negedge spiClk or negedge spiRstN) begin
    if (!spiRstN) begin
      shift_reg <= '0;
      bitCnt_reg <= '0;
      rdReq_reg <= 1'b0;
    end else if (!selectN) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], serialIn};
      if (bitCnt_reg != FRAME_OVER) begin
        bitCnt_reg <= bitCnt_reg + 5'h01;
      end
      if (bitCnt_reg == ADDR_DONE - 5'h01) begin
        rdReq_reg <= 1'b1;
      end
    end
  end

  // Low byte carries data, upper byte zero. readData_reg is quasi-static:
  // the core loads it within about 50 ns of the eighth falling edge, so a
  // clock low phase shorter than that would shift out stale data.
  always_ff @(posedge spiClk or negedge spiRstN) begin
    if (!spiRstN) begin
      outBit_reg <= 1'b0;
    end else if (!selectN) begin
      if (bitCnt_reg >= ADDR_DONE && bitCnt_reg < FRAME_LEN) begin
        outBit_reg <= readData_reg[3'(LAST_BIT - bitCnt_reg)];
      end else begin
        outBit_reg <= 1'b0;
      end
    end
  end

  assign serialOut = outBit_reg;
  assign serialOutOe = ~selectN & busOn;

  // =========================================================
  // Synchronisers into the core clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      syn1_reg <= SYN_RESET;
      syn2_reg <= SYN_RESET;
      syn3_reg <= SYN_RESET;
      synF_reg <= SYN_RESET;
      prevF_reg <= SYN_RESET;
    end else begin
      syn1_reg <= {enablePin, selectN, rdReq_reg};
      syn2_reg <= syn1_reg;
      syn3_reg <= syn2_reg;
      synF_reg <= (syn2_reg & syn3_reg) | (synF_reg & (syn2_reg | syn3_reg));
      prevF_reg <= synF_reg;
    end
  end

  assign selRise = synF_reg[SYN_CS] & ~prevF_reg[SYN_CS];
  assign rdRise = synF_reg[SYN_RD] & ~prevF_reg[SYN_RD];
  assign enRise = synF_reg[SYN_EN] & ~prevF_reg[SYN_EN];
  assign busOn = synF_reg[SYN_EN] & ~sleep_reg;

  // =========================================================
  // Frame decode; shift_reg and bitCnt_reg are frozen once select_n is high
  assign addr = shift_reg[ADDR_MSB:ADDR_LSB];
  assign addrHiZero = shift_reg[ADDR_ZERO_MSB:ADDR_ZERO_LSB] == 2'h0;
  assign wrData = shift_reg[WDATA_MSB:0];
  assign lockFieldIn = wrData[LOCK_MSB:LOCK_LSB];
  // Mid-frame the command byte still sits in the low half of the shifter
  assign rdAddr = shift_reg[ADDR_MSB-DATA_W:ADDR_LSB-DATA_W];
  assign rdHiZero = shift_reg[ADDR_ZERO_MSB-DATA_W:ADDR_ZERO_LSB-DATA_W] == 2'h0;
  assign rdIdx = CTRL_IDX_W'(rdAddr - ADDR_CTRL_FIRST);
  assign frameOk = bitCnt_reg == FRAME_LEN;
  assign wrIdx = CTRL_IDX_W'(addr - ADDR_CTRL_FIRST);
  assign wrValid = selRise & busOn & frameOk & ~shift_reg[RW_POS] & addrHiZero &
                   addr >= ADDR_CTRL_FIRST & addr <= ADDR_CTRL_LAST;
  assign lockActive = ctrl_reg[LOCK_IDX][LOCK_MSB:LOCK_LSB] == LOCK_ENGAGED;
  assign wrAllowed = wrValid & (~lockActive | wrIdx == LOCK_IDX);
  // Clearing faults is not a setting, so the lock does not block it
  assign clrFlt = wrValid & wrIdx == DRIVE_MODE_IDX & wrData[FAULT_CLEAR_POS];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      frameClr_reg <= 1'b0;
    end else begin
      frameClr_reg <= selRise;
    end
  end

  // =========================================================
  // Enable pin: reset pulse versus sleep
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lowCnt_reg <= '0;
    end else if (synF_reg[SYN_EN]) begin
      lowCnt_reg <= '0;
    end else if (lowCnt_reg != LOW_TOP) begin
      lowCnt_reg <= lowCnt_reg + LOW_W'(1);
    end
  end

  assign enPulse = enRise & ~sleep_reg & lowCnt_reg <= LOW_WIN;
  assign clrAll = clrFlt | enPulse;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sleep_reg <= 1'b0;
    end else if (lowCnt_reg == LOW_TOP && !synF_reg[SYN_EN]) begin
      sleep_reg <= 1'b1;
    end else if (enRise) begin
      sleep_reg <= 1'b0;
    end
  end

  assign sleepMode = sleep_reg;

  // =========================================================
  // Fault latches; a new event in the clearing cycle survives
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      faultLat_reg <= '0;
      diagLat_reg <= '0;
    end else if (clrAll) begin
      faultLat_reg <= faultEvt;
      diagLat_reg <= {diagEvtC, diagEvtB, diagEvtA};
    end else begin
      faultLat_reg <= faultLat_reg | faultEvt;
      diagLat_reg <= diagLat_reg | {diagEvtC, diagEvtB, diagEvtA};
    end
  end

  assign faultAny = |faultLat_reg | |diagLat_reg;
  assign partialShutdown = faultAny;

  // =========================================================
  // Control registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < CTRL_COUNT; i++) begin
        ctrl_reg[i] <= CTRL_RESET[i];
      end
    end else if (wrAllowed) begin
      ctrl_reg[wrIdx] <= wrData & CTRL_WMASK[wrIdx];
    end
  end

  always_comb begin
    for (int i = 0; i < CTRL_COUNT; i++) begin
      ctrlFlat[i*DATA_W +: DATA_W] = ctrl_reg[i];
    end
  end

  // =========================================================
  // Read path, loaded once the address byte is in
  always_comb begin
    readMux = '0;
    if (rdHiZero) begin
      unique case (rdAddr)
        ADDR_FAULT: readMux = {faultAny, faultLat_reg};
        ADDR_DIAG_A: readMux = diagLat_reg[0];
        ADDR_DIAG_B: readMux = diagLat_reg[1];
        ADDR_DIAG_C: readMux = diagLat_reg[2];
        default: begin
          if (rdAddr >= ADDR_CTRL_FIRST && rdAddr <= ADDR_CTRL_LAST) begin
            readMux = ctrl_reg[rdIdx];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readData_reg <= '0;
    end else if (rdRise) begin
      readData_reg <= readMux;
    end
  end

  // =========================================================
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  property p_clear_latches;
    clrAll |=> faultLat_reg == $past(faultEvt) && diagLat_reg[0] == $past(diagEvtA);
  endproperty
  a_clear_latches: assert property (p_clear_latches)
    else $error("fault clear did not empty the latches");

  property p_hold_latches;
    !clrAll |=> (faultLat_reg & $past(faultLat_reg)) == $past(faultLat_reg);
  endproperty
  a_hold_latches: assert property (p_hold_latches)
    else $error("latched fault lost without a clear");

  property p_shutdown_holds;
    partialShutdown && !clrAll |=> partialShutdown;
  endproperty
  a_shutdown_holds: assert property (p_shutdown_holds)
    else $error("partial shutdown left without a clear");

  property p_bad_frame;
    selRise && bitCnt_reg != FRAME_LEN |=> $stable(ctrlFlat);
  endproperty
  a_bad_frame: assert property (p_bad_frame)
    else $error("frame error changed a control register");

  property p_locked;
    wrValid && lockActive && wrIdx != LOCK_IDX |=> $stable(ctrlFlat);
  endproperty
  a_locked: assert property (p_locked)
    else $error("write passed through the lock");

  property p_lock_write;
    wrValid && wrIdx == LOCK_IDX |=> lockActive == ($past(lockFieldIn) == LOCK_ENGAGED);
  endproperty
  a_lock_write: assert property (p_lock_write)
    else $error("valid write did not update the lock register");

  property p_release;
    serialOutOe |-> !selectN;
  endproperty
  a_release: assert property (p_release)
    else $error("serial output driven while deselected");

  property p_sleep_entry;
    lowCnt_reg == LOW_TOP && !synF_reg[SYN_EN] |=> sleepMode && !serialOutOe;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("long enable low did not enter sleep");

  property p_fault_summary;
    rdRise && rdHiZero && rdAddr == ADDR_FAULT |=>
      readData_reg[FAULT_ANY_POS] == $past(faultAny);
  endproperty
  a_fault_summary: assert property (p_fault_summary)
    else $error("fault summary bit disagrees with latches");
endmodule
`default_nettype wire

// ### shared/srf_pkg.sv
`default_nettype none
package srf_pkg;
  // =========================================================
  // Frame layout
  localparam int DATA_W = 8;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] ADDR_DONE = 5'h08;
  localparam logic [CNT_W-1:0] LAST_BIT = 5'h0f;
  localparam logic [CNT_W-1:0] FRAME_LEN = 5'h10;
  localparam logic [CNT_W-1:0] FRAME_OVER = 5'h11;
  localparam int RW_POS = 15;
  localparam int ADDR_ZERO_MSB = 14;
  localparam int ADDR_ZERO_LSB = 13;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 8;
  localparam int WDATA_MSB = 7;

  // =========================================================
  // Register map
  localparam logic [4:0] ADDR_FAULT = 5'h00;
  localparam logic [4:0] ADDR_DIAG_A = 5'h01;
  localparam logic [4:0] ADDR_DIAG_B = 5'h02;
  localparam logic [4:0] ADDR_DIAG_C = 5'h03;
  localparam logic [4:0] ADDR_CTRL_FIRST = 5'h04;
  localparam logic [4:0] ADDR_CTRL_LAST = 5'h11;
  localparam int CTRL_COUNT = 14;
  localparam int CTRL_IDX_W = 4;
  localparam logic [CTRL_IDX_W-1:0] DRIVE_MODE_IDX = 4'h0;
  localparam logic [CTRL_IDX_W-1:0] LOCK_IDX = 4'h9;
  localparam int FAULT_ANY_POS = 7;
  localparam int FAULT_CLEAR_POS = 7;
  localparam int LOCK_MSB = 7;
  localparam int LOCK_LSB = 5;
  localparam logic [2:0] LOCK_ENGAGED = 3'h6;
  // Index 13 (0x11) on the left, index 0 (0x04) on the right
  localparam logic [CTRL_COUNT-1:0][DATA_W-1:0] CTRL_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h99,
    8'h99, 8'h99, 8'hff, 8'hff, 8'hff, 8'h40, 8'h00};
  // Reserved bits and the self-clearing fault clear bit never store
  localparam logic [CTRL_COUNT-1:0][DATA_W-1:0] CTRL_WMASK = {
    8'h3f, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h7f};

  // =========================================================
  // Pin synchroniser lanes and timing
  localparam int SYN_EN = 2;
  localparam int SYN_CS = 1;
  localparam int SYN_RD = 0;
  localparam logic [2:0] SYN_RESET = 3'h6;
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_WINDOW_NS = 40000;
endpackage
`default_nettype wire

// ### dv/srf_spi_master.sv
`timescale 1ns/10ps
`default_nettype none
module srf_spi_master (
  output logic spiClk,
  output logic selectN,
  output logic serialIn,
  input wire logic serialOut
);
  // ==========================================
  // Frame driver, serial clock parked low between frames
  initial begin
    spiClk = 1'b0;
    selectN = 1'b1;
    serialIn = 1'b0;
  end

  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    selectN = 1'b0;
    for (int i = 0; i < n; i++) begin
      #62.5;
      spiClk = 1'b1;
      serialIn = (i < 16) ? w[15-i] : 1'b0;
      #62.5;
      spiClk = 1'b0;
      r = {r[14:0], serialOut};
    end
    #62.5;
    selectN = 1'b1;
    // Released data line must not keep its last value
    serialIn = ~serialIn;
    // Gap also covers the core landing delay after select rises
    #600;
  endtask
endmodule
`default_nettype wire

// ### dv/spi_register_fault_interface_bench.sv
`timescale 1ns/10ps
`default_nettype none
module spi_register_fault_interface_bench;
  import srf_pkg::*;
  logic clock = 1'b0;
  logic resetn, enablePin, spiClk, selectN, serialIn;
  logic serialOut, serialOutOe, partialShutdown, sleepMode, lockActive;
  logic [6:0] faultEvt;
  logic [7:0] diagEvtA, diagEvtB, diagEvtC, d;
  logic [111:0] ctrlFlat;
  int failures = 0;
  int check_count = 0;
  int ctrl [14];
  int diag [3];
  int fault, asleep, i;

  always #5 clock = ~clock;

  srf_spi_regs #(.RST_WINDOW_CYC(20)) dut_u (.clock(clock), .resetn(resetn),
    .spiClk(spiClk), .selectN(selectN), .serialIn(serialIn), .enablePin(enablePin),
    .faultEvt(faultEvt), .diagEvtA(diagEvtA), .diagEvtB(diagEvtB), .diagEvtC(diagEvtC),
    .serialOut(serialOut), .serialOutOe(serialOutOe), .partialShutdown(partialShutdown),
    .sleepMode(sleepMode), .lockActive(lockActive), .ctrlFlat(ctrlFlat));
  srf_spi_master master_u (.spiClk(spiClk), .selectN(selectN), .serialIn(serialIn),
    .serialOut(serialOut));

  // ==========================================
  // Checking helpers and reference model
  task summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rd(input int a);
    if (a == 0)
      return 8'(fault) | (((fault | diag[0] | diag[1] | diag[2]) != 0) ? 8'h80 : 8'h00);
    if (a < 4)
      return 8'(diag[a-1]);
    if (a < 18)
      return 8'(ctrl[a-4]);
    return 8'h00;
  endfunction

  task automatic xfer(input logic rw, input int a, input logic [7:0] v, input int n);
    logic [15:0] r;
    logic [7:0] e;
    bit ok;
    @(posedge clock);
    #1;
    e = rd(a);
    ok = (n == 16) && (asleep == 0);
    fork
      master_u.frame({rw, 2'b00, 5'(a), v}, n, r);
      begin
        #200;
        chk(8'(serialOutOe), 8'(asleep == 0));
      end
    join
    if (ok)
      chk(r[7:0], e);
    // Clearing faults is not a setting, so the lock does not hold it back
    if (ok && !rw && a == 4 && v[7]) begin
      fault = 0;
      diag = '{0, 0, 0};
    end
    if (ok && !rw && a >= 4 && a < 18 && ((ctrl[9] >> 5) != 6 || a == 13))
      ctrl[a-4] = int'(v & CTRL_WMASK[a-4]);
    for (int k = 0; k < 14; k++)
      chk(ctrlFlat[k*8 +: 8], 8'(ctrl[k]));
    chk(8'(serialOutOe), 8'h00);
  endtask

  task fire;
    @(posedge clock);
    #1;
    faultEvt = 7'($urandom) | 7'h01;
    {diagEvtA, diagEvtB, diagEvtC} = 24'($urandom);
    fault |= faultEvt;
    diag[0] |= diagEvtA;
    diag[1] |= diagEvtB;
    diag[2] |= diagEvtC;
    @(posedge clock);
    #1;
    faultEvt = 7'h00;
    {diagEvtA, diagEvtB, diagEvtC} = 24'h000000;
  endtask

  task drv_en(input logic v, input int n);
    @(posedge clock);
    #1;
    enablePin = v;
    repeat (n) @(posedge clock);
  endtask

  task read_status;
    for (int a = 0; a < 4; a++)
      xfer(1'b1, a, 8'h00, 16);
    chk(8'(partialShutdown), rd(0) >> 7);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    enablePin = 1'b1;
    faultEvt = 7'h00;
    {diagEvtA, diagEvtB, diagEvtC} = 24'h000000;
    void'($urandom(32'h677e8e3b));
    for (int k = 0; k < 14; k++)
      ctrl[k] = int'(CTRL_RESET[k]);
    fault = 0;
    diag = '{0, 0, 0};
    asleep = 0;
    repeat (3) @(posedge clock);
    #1;
    resetn = 1'b1;
    repeat (5) @(posedge clock);
    for (int a = 0; a < 22; a++)
      xfer(1'b1, a, 8'h00, 16);
    for (int a = 0; a < 18; a++) begin
      d = 8'($urandom);
      if (a == 13)
        d[7:5] = 3'b000;
      xfer(1'b0, a, d, 16);
    end
    xfer(1'b0, 5, 8'h5a, 15);
    xfer(1'b0, 5, 8'ha5, 17);
    fire();
    read_status();
    read_status();
    xfer(1'b0, 4, 8'h80 | d, 16);
    read_status();
    fire();
    drv_en(1'b0, 10);
    drv_en(1'b1, 10);
    fault = 0;
    diag = '{0, 0, 0};
    read_status();
    fire();
    drv_en(1'b0, 0);
    for (i = 0; i < 60 && sleepMode !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (i == 60) begin
      failures++;
      summarize();
    end
    chk(8'(i > 20), 8'h01);
    asleep = 1;
    xfer(1'b0, 5, 8'h11, 16);
    drv_en(1'b1, 10);
    asleep = 0;
    chk(8'(sleepMode), 8'h00);
    read_status();
    xfer(1'b0, 13, 8'hc0, 16);
    chk(8'(lockActive), 8'h01);
    xfer(1'b0, 5, 8'h3c, 16);
    xfer(1'b0, 13, 8'h00, 16);
    chk(8'(lockActive), 8'h00);
    xfer(1'b0, 5, 8'h3c, 16);
    summarize();
  end
endmodule
`default_nettype wire
